// *** rtl/aord_pkg.sv ***
// Package for the over-range detector: widths, hold codes, sample carrier.
// Assumes samples arrive on the detector clock as two's complement words.
package aord_pkg;

   localparam int          AORD_SAMPLE_W  = 12;
   localparam int          AORD_CMP_W     = 8;
   localparam int          AORD_HOLD_SEL_W = 3;
   localparam int          AORD_CHANNELS  = 4;
   localparam int          AORD_CNT_W     = 11;
   localparam logic [10:0] AORD_HOLD_BASE = 11'h008;
   localparam logic [10:0] AORD_MAG_MAX   = 11'h7FF;
   localparam logic [11:0] AORD_MOST_NEG  = 12'h800;
   localparam logic [7:0]  AORD_TH_RESET  = 8'hFF;

   // One sample per channel, channel A in slot 0
   typedef struct packed {
      logic [AORD_CHANNELS-1:0][AORD_SAMPLE_W-1:0] smp;
      logic                                        valid;
   } aord_samples_t;

   // Static settings shared by all channels
   typedef struct packed {
      logic [AORD_CMP_W-1:0]      threshold;
      logic                       enable;
      logic [AORD_HOLD_SEL_W-1:0] hold_sel;
   } aord_cfg_t;

endpackage

// *** rtl/aord_detector.sv ***
// Over-range detector for four sample streams with per-channel flag pins.
// Assumes samples and settings are synchronous to clk; no software registers.
//
// What this block does
// - Every 12-bit sample of each channel is checked, one cycle pipeline.
// - Magnitude is formed; only its upper 8 bits are compared to threshold.
// - One threshold serves all four channels.
// - Most negative code saturates to 2047, so both full scales give 255.
// - Flags stay low unless detect enable is 1.
// - Flag is 1 when magnitude meets threshold within hold period, else 0.
// - Flags for channels A, B, C, D drive four separate output pins.
// - Hold after last hit is 8 shifted left by the 3-bit select code.
// - Samples are signed two's complement from -2048 to +2047.
`timescale 1ns/100ps

module aord_detector
   import aord_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Samples and settings
   input  wire aord_samples_t samples_in,
   input  wire aord_cfg_t     cfg_in,
   // Flag pins
   output logic               over_range_flag_ch_a,
   output logic               over_range_flag_ch_b,
   output logic               over_range_flag_ch_c,
   output logic               over_range_flag_ch_d
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic [1:0] rst_sync_reg;
   logic       rst_int_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // Magnitude and hold length
   // Negating the most negative code overflows 12 bits, hence its own branch
   // Only bits 10 to 3 of the magnitude reach the comparator
   function automatic logic [AORD_CMP_W-1:0] mag_top(input logic [AORD_SAMPLE_W-1:0] s);
      logic [AORD_SAMPLE_W-1:0] neg;
      logic [AORD_SAMPLE_W-2:0] mag;
      neg = '0;
      mag = '0;
      if (s == AORD_MOST_NEG) begin
         mag = AORD_MAG_MAX;
      end else if (s[AORD_SAMPLE_W-1]) begin
         neg = AORD_SAMPLE_W'(~s + 1'b1);
         mag = neg[AORD_SAMPLE_W-2:0];
      end else begin
         mag = s[AORD_SAMPLE_W-2:0];
      end
      return mag[AORD_SAMPLE_W-2 -: AORD_CMP_W];
   endfunction

   function automatic logic [AORD_CNT_W-1:0] hold_len(input logic [AORD_HOLD_SEL_W-1:0] c);
      return AORD_CNT_W'(AORD_HOLD_BASE << c);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel hit, hold counter and flag
   logic [AORD_CHANNELS-1:0]                 hit;
   logic [AORD_CHANNELS-1:0][AORD_CNT_W-1:0] cnt_reg;
   logic [AORD_CHANNELS-1:0][AORD_CNT_W-1:0] cnt_next;
   logic [AORD_CHANNELS-1:0]                 flag_reg;
   logic [AORD_CHANNELS-1:0]                 flag_next;

   // Disable wins over a hit so a switched-off detector never reports
   always_comb begin
      for (int i = 0; i < AORD_CHANNELS; i++) begin
         hit[i] = samples_in.valid && cfg_in.enable
                  && (mag_top(samples_in.smp[i]) >= cfg_in.threshold);
         cnt_next[i]  = cnt_reg[i];
         flag_next[i] = flag_reg[i];
         if (!cfg_in.enable) begin
            cnt_next[i]  = '0;
            flag_next[i] = 1'b0;
         end else if (hit[i]) begin
            cnt_next[i]  = AORD_CNT_W'(hold_len(cfg_in.hold_sel) - 1'b1);
            flag_next[i] = 1'b1;
         end else if (cnt_reg[i] != '0) begin
            cnt_next[i] = AORD_CNT_W'(cnt_reg[i] - 1'b1);
         end else begin
            flag_next[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cnt_reg  <= '0;
         flag_reg <= '0;
      end else begin
         cnt_reg  <= cnt_next;
         flag_reg <= flag_next;
      end
   end

   // Straight from flops; pin order A to D
   assign over_range_flag_ch_a = flag_reg[0];
   assign over_range_flag_ch_b = flag_reg[1];
   assign over_range_flag_ch_c = flag_reg[2];
   assign over_range_flag_ch_d = flag_reg[3];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Cycles since channel A last hit; saturates so a long idle cannot wrap
   logic [AORD_CNT_W-1:0] low_run_reg;
   logic [AORD_CNT_W-1:0] low_run_next;

   always_comb begin
      low_run_next = low_run_reg;
      if (hit[0]) begin
         low_run_next = '0;
      end else if (low_run_reg != {AORD_CNT_W{1'b1}}) begin
         low_run_next = AORD_CNT_W'(low_run_reg + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         low_run_reg <= '0;
      end else begin
         low_run_reg <= low_run_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Set path: one cycle from hit to flag on every pin
   hit_sets_flag_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[0] |=> over_range_flag_ch_a) else $error("flag A not set by hit");
   hit_flag_b_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[1] |=> over_range_flag_ch_b) else $error("flag B not set by hit");
   hit_flag_c_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[2] |=> over_range_flag_ch_c) else $error("flag C not set by hit");
   hit_flag_d_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[3] |=> over_range_flag_ch_d) else $error("flag D not set by hit");

   // A pin only rises after a hit on its own channel, never a neighbour's
   rise_a_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      $rose(over_range_flag_ch_a) |-> $past(hit[0])) else $error("flag A rose without hit");
   rise_b_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      $rose(over_range_flag_ch_b) |-> $past(hit[1])) else $error("flag B rose without hit");
   rise_c_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      $rose(over_range_flag_ch_c) |-> $past(hit[2])) else $error("flag C rose without hit");
   rise_d_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      $rose(over_range_flag_ch_d) |-> $past(hit[3])) else $error("flag D rose without hit");

   // Full scale of either sign must trip even the highest threshold
   pos_full_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      samples_in.valid && cfg_in.enable && samples_in.smp[3] == {1'b0, AORD_MAG_MAX}
      |=> over_range_flag_ch_d) else $error("positive full scale not flagged");
   neg_full_c_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      samples_in.valid && cfg_in.enable && samples_in.smp[2] == AORD_MOST_NEG
      |=> over_range_flag_ch_c) else $error("most negative code not flagged on C");

   ////////////////////////////////////////////////////////////////////////////
   // Clear and hold paths
   disabled_mid_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      !cfg_in.enable |=> !over_range_flag_ch_b && !over_range_flag_ch_c)
      else $error("flag B or C high while disabled");
   disabled_cnt_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      !cfg_in.enable |=> cnt_reg == '0) else $error("hold count kept while disabled");
   reload_cnt_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[0] |=> cnt_reg[0] == AORD_CNT_W'($past(hold_len(cfg_in.hold_sel)) - 1'b1))
      else $error("hold count not restarted by hit");
   count_done_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      cfg_in.enable && !hit[0] && cnt_reg[0] == '0 |=> !over_range_flag_ch_a)
      else $error("flag A kept after count ran out");
   hold_min_b_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[1] && cfg_in.hold_sel == 3'h0 ##1 (cfg_in.enable && cfg_in.hold_sel == 3'h0)[*7]
      |-> over_range_flag_ch_b) else $error("hold on B shorter than eight");
   hold_min_c_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[2] && cfg_in.hold_sel == 3'h0 ##1 (cfg_in.enable && cfg_in.hold_sel == 3'h0)[*7]
      |-> over_range_flag_ch_c) else $error("hold on C shorter than eight");
   hold_min_d_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[3] && cfg_in.hold_sel == 3'h0 ##1 (cfg_in.enable && cfg_in.hold_sel == 3'h0)[*7]
      |-> over_range_flag_ch_d) else $error("hold on D shorter than eight");
   below_th_b_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      !over_range_flag_ch_b && !hit[1] |=> !over_range_flag_ch_b)
      else $error("flag B set without hit");
   below_th_d_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      !over_range_flag_ch_d && !hit[3] |=> !over_range_flag_ch_d)
      else $error("flag D set without hit");

   // Checks carried over for channels A to D and the shared settings
   disabled_low_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      !cfg_in.enable |=> !over_range_flag_ch_a && !over_range_flag_ch_d)
      else $error("flag high while disabled");
   most_neg_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      samples_in.valid && cfg_in.enable && samples_in.smp[1] == AORD_MOST_NEG
      |=> over_range_flag_ch_b) else $error("most negative code not flagged");
   hold_min_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      hit[0] && cfg_in.hold_sel == 3'h0 ##1 (cfg_in.enable && cfg_in.hold_sel == 3'h0)[*7]
      |-> over_range_flag_ch_a) else $error("hold shorter than eight");
   hold_end_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      low_run_reg > hold_len(cfg_in.hold_sel) && $stable(cfg_in.hold_sel)
      |-> !over_range_flag_ch_a) else $error("flag outlived hold");
   below_th_a: assert property (@(posedge clk) disable iff (!rst_int_n)
      !over_range_flag_ch_c && !hit[2] |=> !over_range_flag_ch_c)
      else $error("flag C set without hit");

endmodule

// *** tb/aord_gain_ctrl.sv ***
// Downstream gain manager model: holds gain low while any flag is up.
// Assumes the flags are synchronous to clk.
`timescale 1ns/100ps
module aord_gain_ctrl (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Flags in, gain state out
   input  wire logic [3:0] flags,
   output logic            gain_low
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) gain_low <= 1'b0;
      else gain_low <= |flags;
   end
endmodule

// *** tb/test_aord_detector.sv ***
// Testbench for the over-range detector: thresholds, hold codes, enable.
// Assumes one cycle from sample to flag; inputs change at falling edges.
`timescale 1ns/100ps
module test_aord_detector;
   import aord_pkg::*;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   aord_samples_t smp = '0;
   aord_cfg_t     cfg = '{8'hE4, 1'b1, 3'h0};
   logic [3:0]    flags;
   logic          gain_low;
   int            bad_count = 0;
   int            checks = 0;
   initial forever #12.5 clk = ~clk;
   aord_detector aord_detector_i (.clk(clk), .rst_n(rst_n), .samples_in(smp), .cfg_in(cfg),
      .over_range_flag_ch_a(flags[0]), .over_range_flag_ch_b(flags[1]),
      .over_range_flag_ch_c(flags[2]), .over_range_flag_ch_d(flags[3]));
   aord_gain_ctrl aord_gain_ctrl_i (.clk(clk), .rst_n(rst_n), .flags(flags),
      .gain_low(gain_low));
   task automatic cmp(logic [3:0] got, logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_gain(logic got, logic exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One valid cycle; returns where its flags are first visible
   task automatic hit(logic [11:0] a, logic [11:0] b, logic [11:0] c, logic [11:0] d);
      @(negedge clk);
      smp = {d, c, b, a, 1'b1};
      @(negedge clk);
      smp.valid = 1'b0;
   endtask
   // Flags stay exactly n cycles, then all fall
   task automatic hold_for(int n, logic [3:0] exp);
      repeat (n) begin
         cmp(flags, exp);
         @(negedge clk);
      end
      cmp_gain(gain_low, |exp);
      cmp(flags, 4'h0);
   endtask
   task automatic hold_codes;
      for (int k = 0; k < 8; k++) begin
         cfg.hold_sel = k[2:0];
         hit(12'h7FF, 12'h000, 12'h000, 12'h000);
         hold_for(8 << k, 4'h1);
      end
      cfg.hold_sel = 3'h0;
   endtask
   task automatic thresholds;
      hit(12'h720, 12'h71F, 12'h8E0, 12'h8E1);
      hold_for(8, 4'h5);
      cfg.threshold = 8'hFF;
      hit(12'h800, 12'h810, 12'h7FF, 12'h7F8);
      hold_for(8, 4'hD);
      cfg.threshold = 8'h00;
      hit(12'h000, 12'h001, 12'hFFF, 12'h400);
      hold_for(8, 4'hF);
      cfg.threshold = 8'hE4;
   endtask
   task automatic restart_hold;
      hit(12'h000, 12'h7FF, 12'h000, 12'h000);
      repeat (4) @(negedge clk);
      hit(12'h000, 12'h801, 12'h000, 12'h000);
      hold_for(8, 4'h2);
   endtask
   task automatic disabled;
      hit(12'h7FF, 12'h000, 12'h000, 12'h000);
      cmp(flags, 4'h1);
      cfg.enable = 1'b0;
      @(negedge clk);
      cmp(flags, 4'h0);
      hit(12'h7FF, 12'h800, 12'h7FF, 12'h800);
      hold_for(0, 4'h0);
      @(negedge clk);
      cmp(flags, 4'h0);
      cfg.enable = 1'b1;
      hit(12'h7FF, 12'h000, 12'h000, 12'h800);
      hold_for(8, 4'h9);
      smp = {12'h7FF, 12'h800, 12'h7FF, 12'h800, 1'b0};
      repeat (2) @(negedge clk);
      cmp(flags, 4'h0);
      smp = '0;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      cmp(flags, 4'h0);
      hold_codes();
      thresholds();
      restart_hold();
      disabled();
      tally_and_finish();
   end
   // Whole run is near 54 us; this limit leaves ample margin
   initial begin
      #200us;
      bad_count++;
      tally_and_finish();
   end
endmodule
